// file: logic/sbsp_regs.svh
// Constants for the synchronous burst SRAM port: widths, depth, timing counts.
`ifndef SBSP_REGS_SVH
`define SBSP_REGS_SVH

`define SBSP_ADDR_W 17
`define SBSP_DATA_W 32
`define SBSP_LANES 4
`define SBSP_DEPTH 131072
`define SBSP_CLK_PERIOD_NS 100
`define SBSP_SLEEP_TRANS_TCYC 2
`define SBSP_SLEEP_TRANS_CYC (`SBSP_SLEEP_TRANS_TCYC * `SBSP_CLK_PERIOD_NS / `SBSP_CLK_PERIOD_NS)
`define SBSP_BE_NONE 4'h0
`define SBSP_BE_ALL 4'hF

`endif

// file: logic/sbsp_pkg.sv
// Types and burst address arithmetic for the synchronous burst SRAM port.
package sbsp_pkg;

    typedef enum logic [1:0] {
        SBSP_AWAKE  = 2'h0,
        SBSP_ENTER  = 2'h1,
        SBSP_ASLEEP = 2'h3,
        SBSP_LEAVE  = 2'h2
    } sbsp_sleep_t;

    // Low address bits of a burst: interleaved uses XOR, linear uses a modulo-four sum.
    function automatic logic [1:0] sbsp_burst_addr(input logic [1:0] first,
                                                   input logic [1:0] step,
                                                   input logic interleaved);
        sbsp_burst_addr = interleaved ? (first ^ step) : 2'(first + step);
    endfunction

endpackage

// file: logic/sbsp_burst_ctr.sv
// Two-bit wrap-around burst counter with linear or interleaved order.
`timescale 1ns/1ps
`default_nettype none
module sbsp_burst_ctr (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control.
    input wire logic load,
    input wire logic [1:0] load_val,
    input wire logic advance,
    input wire logic interleaved,
    // Current low address bits.
    output logic [1:0] low_addr
);
    import sbsp_pkg::*;

    logic [1:0] first_reg;
    logic [1:0] step_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            first_reg <= 2'h0;
        end else if (load) begin
            first_reg <= load_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_reg <= 2'h0;
        end else if (load) begin
            step_reg <= 2'h0;
        end else if (advance) begin
            step_reg <= 2'(step_reg + 2'h1);
        end
    end

    assign low_addr = sbsp_burst_addr(first_reg, step_reg, interleaved);

endmodule
`default_nettype wire

// file: logic/sbsp_port.sv
// Synchronous interface logic of a flow-through burst SRAM with its storage array.
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_regs.svh"
module sbsp_port (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Address and strobes.
    input wire logic [`SBSP_ADDR_W-1:0] ADDR,
    input wire logic CONTROLLER_ADDR_STROBE_N,
    input wire logic PROCESSOR_ADDR_STROBE_N,
    input wire logic BURST_ADVANCE_N,
    // Chip selects.
    input wire logic CHIP_SELECT_FIRST_N,
    input wire logic CHIP_SELECT_SECOND,
    input wire logic CHIP_SELECT_THIRD_N,
    // Write controls.
    input wire logic GLOBAL_WRITE_N,
    input wire logic BYTE_WRITE_ENABLE_N,
    input wire logic [`SBSP_LANES-1:0] BYTE_SELECT_N,
    // Asynchronous controls and strap.
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQUEST,
    input wire logic BURST_INTERLEAVED,
    // Data lines, split into input, output and enable.
    input wire logic [`SBSP_DATA_W-1:0] DATA_I,
    output logic [`SBSP_DATA_W-1:0] DATA_O,
    output logic DATA_OE,
    input wire logic [`SBSP_LANES-1:0] PARITY_LINES_I,
    output logic [`SBSP_LANES-1:0] PARITY_LINES_O,
    output logic PARITY_LINES_OE,
    // Status.
    output sbsp_pkg::sbsp_sleep_t SLEEP_STATE
);
    import sbsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for asynchronous pins.
    logic [1:0] oe_n_sync_reg;
    logic [1:0] sleep_sync_reg;
    logic [1:0] mode_sync_reg;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            oe_n_sync_reg <= 2'h3;
            sleep_sync_reg <= 2'h0;
            mode_sync_reg <= 2'h3;
        end else begin
            oe_n_sync_reg <= {oe_n_sync_reg[0], OUTPUT_ENABLE_N};
            sleep_sync_reg <= {sleep_sync_reg[0], SLEEP_REQUEST};
            mode_sync_reg <= {mode_sync_reg[0], BURST_INTERLEAVED};
        end
    end

    wire logic oe_n = oe_n_sync_reg[1];
    wire logic sleep_req = sleep_sync_reg[1];
    wire logic interleaved = mode_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep sequencing.
    sbsp_sleep_t sleep_reg;
    sbsp_sleep_t sleep_next;
    logic [1:0] sleep_cnt_reg;
    wire logic trans_done = (sleep_cnt_reg == 2'(`SBSP_SLEEP_TRANS_CYC - 1));

    always_comb begin
        sleep_next = sleep_reg;
        case (sleep_reg)
            SBSP_AWAKE: if (sleep_req) sleep_next = SBSP_ENTER;
            SBSP_ENTER: if (trans_done) sleep_next = SBSP_ASLEEP;
            SBSP_ASLEEP: if (!sleep_req) sleep_next = SBSP_LEAVE;
            SBSP_LEAVE: if (trans_done) sleep_next = SBSP_AWAKE;
            default: sleep_next = SBSP_AWAKE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sleep_reg <= SBSP_AWAKE;
            sleep_cnt_reg <= 2'h0;
        end else begin
            sleep_reg <= sleep_next;
            sleep_cnt_reg <= (sleep_next != sleep_reg) ? 2'h0 : 2'(sleep_cnt_reg + 2'h1);
        end
    end

    assign SLEEP_STATE = sleep_reg;
    wire logic awake = (sleep_reg == SBSP_AWAKE);

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe decode, taken straight at the clock edge.
    wire logic all_sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
    wire logic p_go = !PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_FIRST_N;
    wire logic c_go = !CONTROLLER_ADDR_STROBE_N && !p_go;
    wire logic load = awake && (p_go || c_go);
    wire logic start = load && all_sel;

    logic selected_reg;
    logic [`SBSP_ADDR_W-1:0] addr_reg;
    logic [1:0] low_addr;

    always_ff @(posedge CLK) begin
        if (SYS_RST || !awake) begin
            selected_reg <= 1'b0;
        end else if (load) begin
            selected_reg <= all_sel;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            addr_reg <= '0;
        end else if (start) begin
            addr_reg <= ADDR;
        end
    end

    wire logic advance = !load && !BURST_ADVANCE_N && selected_reg;

    sbsp_burst_ctr u_ctr (
        .clk(CLK),
        .rst(SYS_RST),
        .load(start),
        .load_val(ADDR[1:0]),
        .advance(advance),
        .interleaved(interleaved),
        .low_addr(low_addr)
    );

    wire logic [`SBSP_ADDR_W-1:0] cur_addr = {addr_reg[`SBSP_ADDR_W-1:2], low_addr};

    ////////////////////////////////////////////////////////////////////////////////
    // Write capture and self-timed commit.
    logic [`SBSP_LANES-1:0] wr_be_reg;
    logic [`SBSP_LANES-1:0] wr_be_next;
    logic [`SBSP_ADDR_W-1:0] wr_addr_reg;
    logic [`SBSP_DATA_W-1:0] wr_data_reg;
    logic [`SBSP_LANES-1:0] wr_par_reg;

    always_comb begin
        if (!awake || p_go || (load && !all_sel) || (!load && !selected_reg)) begin
            wr_be_next = `SBSP_BE_NONE;
        end else if (!GLOBAL_WRITE_N) begin
            wr_be_next = `SBSP_BE_ALL;
        end else if (!BYTE_WRITE_ENABLE_N) begin
            wr_be_next = ~BYTE_SELECT_N;
        end else begin
            wr_be_next = `SBSP_BE_NONE;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_be_reg <= `SBSP_BE_NONE;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            wr_par_reg <= '0;
        end else begin
            wr_be_reg <= wr_be_next;
            wr_addr_reg <= start ? ADDR : cur_addr;
            wr_data_reg <= DATA_I;
            wr_par_reg <= PARITY_LINES_I;
        end
    end

    logic [`SBSP_DATA_W-1:0] mem_data [0:`SBSP_DEPTH-1];
    logic [`SBSP_LANES-1:0] mem_par [0:`SBSP_DEPTH-1];

    always_ff @(posedge CLK) begin
        for (int i = 0; i < `SBSP_LANES; i++) begin
            if (wr_be_reg[i]) begin
                mem_data[wr_addr_reg][i*8 +: 8] <= wr_data_reg[i*8 +: 8];
                mem_par[wr_addr_reg][i] <= wr_par_reg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and line direction.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DATA_O <= '0;
            PARITY_LINES_O <= '0;
        end else begin
            DATA_O <= mem_data[cur_addr];
            PARITY_LINES_O <= mem_par[cur_addr];
        end
    end

    // Lines are released whenever a write is in flight, whatever the enable says.
    wire logic drive_next = selected_reg && awake && !oe_n && (wr_be_next == `SBSP_BE_NONE)
        && (wr_be_reg == `SBSP_BE_NONE);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DATA_OE <= 1'b0;
            PARITY_LINES_OE <= 1'b0;
        end else begin
            DATA_OE <= drive_next;
            PARITY_LINES_OE <= drive_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_ctrl_load;
        start && c_go |=> addr_reg == $past(ADDR) && low_addr == $past(ADDR[1:0]);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) else $error("address not loaded");

    property p_proc_wins;
        awake && !PROCESSOR_ADDR_STROBE_N && !CONTROLLER_ADDR_STROBE_N && !CHIP_SELECT_FIRST_N
            && !GLOBAL_WRITE_N |=> wr_be_reg == `SBSP_BE_NONE;
    endproperty
    a_proc_wins: assert property (p_proc_wins) else $error("write taken on processor start");

    property p_sleep_entry;
        sleep_reg == SBSP_AWAKE && sleep_req |=> sleep_reg == SBSP_ENTER ##2 sleep_reg == SBSP_ASLEEP
            && !selected_reg;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing wrong");

    // The array is not reset, so flow-through is checked on the cycles that drive the lines.
    property p_flow_read;
        drive_next |=> DATA_O == $past(mem_data[cur_addr]);
    endproperty
    a_flow_read: assert property (p_flow_read) else $error("read data not flow-through");
    property p_drive;
        DATA_OE |-> $past(!oe_n) && $past(selected_reg) && PARITY_LINES_OE;
    endproperty
    a_drive: assert property (p_drive) else $error("lines driven without enable");
    property p_hold;
        !start && !advance |=> $stable(low_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("burst address moved without advance");

    property p_wrap;
        start ##1 (advance [*3]) |=> low_addr == (interleaved ? $past(ADDR[1:0], 4) ^ 2'h3
            : 2'($past(ADDR[1:0], 4) + 2'h3));
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst sequence wrong");
    property p_global;
        c_go && start && !GLOBAL_WRITE_N |=> wr_be_reg == `SBSP_BE_ALL;
    endproperty
    a_global: assert property (p_global) else $error("global write not all bytes");
    property p_deselect;
        load && !all_sel |=> !selected_reg ##1 !DATA_OE;
    endproperty
    a_deselect: assert property (p_deselect) else $error("access without all selects");

    property p_ce1_gate;
        awake && !PROCESSOR_ADDR_STROBE_N && CHIP_SELECT_FIRST_N && CONTROLLER_ADDR_STROBE_N
            |=> $stable(addr_reg) && $stable(selected_reg);
    endproperty
    a_ce1_gate: assert property (p_ce1_gate) else $error("processor strobe not ignored");

    property p_cov_burst;
        start ##1 advance [*3];
    endproperty
    c_cov_burst: cover property (p_cov_burst);
    property p_cov_bytes;
        wr_be_reg != `SBSP_BE_NONE && wr_be_reg != `SBSP_BE_ALL;
    endproperty
    c_cov_bytes: cover property (p_cov_bytes);
    property p_cov_sleep;
        sleep_reg == SBSP_LEAVE ##1 sleep_reg == SBSP_LEAVE ##1 awake;
    endproperty
    c_cov_sleep: cover property (p_cov_sleep);

endmodule
`default_nettype wire

// file: verif/sbsp_host_model.sv
// Far-side host model: resolves the shared data and parity lines.
`timescale 1ns/1ps
`default_nettype none
module sbsp_host_model (
    // Clock.
    input wire logic clk,
    // Host side.
    input wire logic [35:0] host_val,
    input wire logic host_drive,
    // Device side.
    input wire logic [31:0] dev_data,
    input wire logic [3:0] dev_par,
    input wire logic dev_oe,
    // Resolved lines, parity in the top four bits.
    output logic [35:0] lines
);
    logic [35:0] last_reg = '0;

    // Undriven lines flip every cycle so a stale value never passes for data.
    always_comb begin
        if (dev_oe) begin
            lines = {dev_par, dev_data};
        end else if (host_drive) begin
            lines = host_val;
        end else begin
            lines = ~last_reg;
        end
    end

    always_ff @(posedge clk) begin
        last_reg <= lines;
    end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the synchronous burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbsp_pkg::*;
    logic clk = 0, rst = 1, mode = 1, oe_n = 1, sleep = 0, hdrive = 0;
    logic cstb_n = 1, pstb_n = 1, step_n = 1, glob_n = 1, ben_n = 1;
    logic cs1_n = 0, cs2 = 1, cs3_n = 0, doe, poe;
    logic [3:0] bsel_n = 4'hF, dpar;
    logic [16:0] addr = '0;
    logic [35:0] hval = '0, lines;
    logic [31:0] dout;
    sbsp_sleep_t sst;
    logic [35:0] ref_mem [0:131071];
    int fails = 0, checks = 0;

    always #50 clk = ~clk;

    sbsp_port sbsp_port_i (.CLK(clk), .SYS_RST(rst), .ADDR(addr),
        .CONTROLLER_ADDR_STROBE_N(cstb_n), .PROCESSOR_ADDR_STROBE_N(pstb_n),
        .BURST_ADVANCE_N(step_n), .CHIP_SELECT_FIRST_N(cs1_n),
        .CHIP_SELECT_SECOND(cs2), .CHIP_SELECT_THIRD_N(cs3_n),
        .GLOBAL_WRITE_N(glob_n), .BYTE_WRITE_ENABLE_N(ben_n), .BYTE_SELECT_N(bsel_n),
        .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep), .BURST_INTERLEAVED(mode),
        .DATA_I(lines[31:0]), .DATA_O(dout), .DATA_OE(doe),
        .PARITY_LINES_I(lines[35:32]), .PARITY_LINES_O(dpar),
        .PARITY_LINES_OE(poe), .SLEEP_STATE(sst));
    sbsp_host_model sbsp_host_model_i (.clk(clk), .host_val(hval), .host_drive(hdrive),
        .dev_data(dout), .dev_par(dpar), .dev_oe(doe), .lines(lines));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic idle;
        {cstb_n, pstb_n, step_n, glob_n, ben_n, hdrive} = 6'h3E;
        bsel_n = 4'hF;
    endtask

    // The strap only changes while reset is held.
    task automatic reset(input logic m);
        rst = 1;
        mode = m;
        step(4);
        rst = 0;
        check("reset state", {doe, poe, 2'(sst)}, 4'h0);
    endtask

    function automatic logic [1:0] order(input logic [1:0] f, input logic [1:0] s);
        return mode ? f ^ s : 2'(f + s);
    endfunction

    task automatic wr(input logic [16:0] a, input logic [35:0] v, input logic [2:0] cs,
                      input logic g, input logic b, input logic [3:0] sel);
        oe_n = 1;
        step(3);
        addr = a;
        cstb_n = 0;
        {cs1_n, cs2, cs3_n} = cs;
        {glob_n, ben_n, bsel_n} = {g, b, sel};
        hval = v;
        hdrive = 1;
        step(1);
        idle();
        step(1);
        if (cs == 3'h2 && !g) begin
            ref_mem[a] = v;
        end else if (cs == 3'h2 && !b) begin
            for (int l = 0; l < 4; l++) begin
                if (!sel[l]) begin
                    ref_mem[a][8*l +: 8] = v[8*l +: 8];
                    ref_mem[a][32+l] = v[32+l];
                end
            end
        end
    endtask

    task automatic rd(input logic [16:0] a, input int beats, input logic burst_advance);
        oe_n = 0;
        step(2);
        addr = a;
        cstb_n = 0;
        {cs1_n, cs2, cs3_n} = 3'h2;
        {glob_n, ben_n, hdrive} = 3'h6;
        step(1);
        cstb_n = 1;
        step_n = !burst_advance;
        step(1);
        for (int i = 0; i < beats; i++) begin
            check("read data", {dpar, dout}, ref_mem[{a[16:2], order(a[1:0], burst_advance ? 2'(i) : 2'h0)}]);
            check("read enable", {doe, poe}, 2'h3);
            step(1);
        end
        step_n = 1;
    endtask

    task automatic wait_for(input sbsp_sleep_t s);
        int n;
        n = 0;
        while (sst !== s && n < 20) begin
            step(1);
            n++;
        end
        if (sst !== s) begin
            fails++;
            test_done();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_burst;
        for (int i = 0; i < 4; i++) begin
            wr(17'h0_0104 + 17'(i), {4'(i + 1), 32'(i + 1) * 32'h0101_0101}, 3'h2, 0, 1, 4'hF);
        end
        rd(17'h0_0105, 5, 1);
        rd(17'h0_0106, 3, 0);
    endtask

    task automatic t_bytes;
        wr(17'h0_0200, 36'h1_1111_1111, 3'h2, 0, 1, 4'hF);
        wr(17'h0_0200, 36'hA_AAAA_AAAA, 3'h2, 1, 0, 4'hA);
        wr(17'h0_0200, 36'hF_FFFF_FFFF, 3'h2, 1, 1, 4'h0);
        rd(17'h0_0200, 1, 0);
        oe_n = 1;
        step(3);
        check("released", {doe, poe}, 2'h0);
    endtask

    task automatic t_selects;
        wr(17'h0_0104, 36'h5_5555_5555, 3'h6, 0, 1, 4'hF);
        wr(17'h0_0104, 36'h5_5555_5555, 3'h0, 0, 1, 4'hF);
        wr(17'h0_0104, 36'h5_5555_5555, 3'h3, 0, 1, 4'hF);
        rd(17'h0_0104, 1, 0);
    endtask

    // Both strobes low: the processor start ignores the write inputs of that edge.
    task automatic t_priority;
        oe_n = 1;
        step(3);
        addr = 17'h0_0105;
        {cs1_n, cs2, cs3_n} = 3'h2;
        {pstb_n, cstb_n, glob_n} = 3'h0;
        hval = 36'h0_DEAD_BEEF;
        hdrive = 1;
        step(1);
        // The processor-started write takes its controls one edge after the start.
        {pstb_n, cstb_n, glob_n, ben_n, bsel_n} = 8'hEE;
        hval = 36'h0_0000_0011;
        step(1);
        idle();
        step(2);
        ref_mem[17'h0_0105][7:0] = 8'h11;
        ref_mem[17'h0_0105][32] = 1'b0;
        rd(17'h0_0105, 1, 0);
        pstb_n = 0;
        cs1_n = 1;
        step(2);
        check("gated enable", {doe, poe}, 2'h3);
        check("gated data", {dpar, dout}, ref_mem[17'h0_0105]);
        idle();
    endtask

    task automatic t_sleep;
        sleep = 1;
        wait_for(SBSP_ENTER);
        step(2);
        check("sleep entered", sst, SBSP_ASLEEP);
        sleep = 0;
        wait_for(SBSP_LEAVE);
        step(2);
        check("sleep left", sst, SBSP_AWAKE);
        step(2);
        rd(17'h0_0200, 1, 0);
    endtask

    initial begin
        reset(1'b0);
        t_burst();
        reset(1'b1);
        t_burst();
        t_bytes();
        t_selects();
        t_priority();
        t_sleep();
        test_done();
    end
endmodule
`default_nettype wire
